// ===== shared/etsss_defines.vh
`ifndef ETSSS_DEFINES_VH
`define ETSSS_DEFINES_VH

// register bus geometry
`define ETSSS_ADDR_W 16
`define ETSSS_DATA_W 32

// sample register byte offsets
`define ETSSS_OFS_S2_NANOS 16'h0560
`define ETSSS_OFS_S2_SECS 16'h0564
`define ETSSS_OFS_S2_PHASE 16'h0568
`define ETSSS_OFS_S3_NANOS 16'h056c
`define ETSSS_OFS_S3_SECS 16'h0570
`define ETSSS_OFS_S3_PHASE 16'h0574

// block-local control and status offsets
`define ETSSS_OFS_UNIT_INDEX 16'h0500
`define ETSSS_OFS_STATUS 16'h05f0

// field positions
`define ETSSS_EDGE_BIT 30
`define ETSSS_NANOS_MSB 29
`define ETSSS_PHASE_MSB 2
`define ETSSS_PTR_BIT 8
`define ETSSS_ST_VALID2_BIT 0
`define ETSSS_ST_VALID3_BIT 1
`define ETSSS_ST_OVR2_BIT 2
`define ETSSS_ST_OVR3_BIT 3
`define ETSSS_ST_BADSLOT_BIT 4

// phase codes per 8ns slot of the 40ns period
`define ETSSS_PH_0NS 3'h0
`define ETSSS_PH_8NS 3'h1
`define ETSSS_PH_16NS 3'h2
`define ETSSS_PH_24NS 3'h3
`define ETSSS_PH_32NS 3'h4
`define ETSSS_SLOT_LAST 3'h4

// reset values
`define ETSSS_RST_WORD 32'h0000_0000
`define ETSSS_RST_NANOS 30'h0000_0000
`define ETSSS_RST_PHASE 3'h0
`define ETSSS_RST_PTR 1'b0

`endif

// ===== src/etsss_phase_enc.v
`timescale 1ns/1ps
`include "etsss_defines.vh"

module etsss_phase_enc (
  // slot of the 25MHz period, 0..4
  input wire [2:0] slot_i,
  // encoded phase and range flag
  output reg [2:0] code_o,
  output reg bad_o
);

  always @* begin
    bad_o = 1'b0;
    case (slot_i)
      3'h0: code_o = `ETSSS_PH_0NS;
      3'h1: code_o = `ETSSS_PH_8NS;
      3'h2: code_o = `ETSSS_PH_16NS;
      3'h3: code_o = `ETSSS_PH_24NS;
      3'h4: code_o = `ETSSS_PH_32NS;
      default: begin
        // reserved codes are never produced
        code_o = `ETSSS_PH_0NS;
        bad_o = 1'b1;
      end
    endcase
  end

endmodule

// ===== src/etsss_sample_slot.v
`timescale 1ns/1ps
`include "etsss_defines.vh"

module etsss_sample_slot (
  // clock and reset
  input wire ref_clk_i,
  input wire sys_rst_i,
  // capture load
  input wire load_i,
  input wire rising_i,
  input wire [29:0] nanos_i,
  input wire [31:0] secs_i,
  input wire [2:0] phase_i,
  // formatted register words
  output wire [31:0] nanos_word_o,
  output wire [31:0] secs_word_o,
  output wire [31:0] phase_word_o
);

  reg edge_reg;
  reg [29:0] nanos_reg;
  reg [31:0] secs_reg;
  reg [2:0] phase_reg;

  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      edge_reg <= 1'b0;
      nanos_reg <= `ETSSS_RST_NANOS;
      secs_reg <= `ETSSS_RST_WORD;
      phase_reg <= `ETSSS_RST_PHASE;
    end else if (load_i) begin
      edge_reg <= rising_i;
      nanos_reg <= nanos_i;
      secs_reg <= secs_i;
      phase_reg <= phase_i;
    end
  end

  // edge flag above nanos, bit 31 zero
  assign nanos_word_o = {1'b0, edge_reg, nanos_reg}; // [RL1] [RL2] [RL8]
  assign secs_word_o = secs_reg; // [RL3]
  assign phase_word_o = {29'h0000_0000, phase_reg}; // [RL4] [RL8]

endmodule

// ===== src/etsss_top.v
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`include "etsss_defines.vh"

// Functional notes
// RL1 - bit 30 shows edge, 1 rising
// RL2 - second sample nanos in bits 29:0
// RL3 - seconds in own full 32-bit register
// RL4 - 3-bit phase gives 8ns slot
// RL5 - 24ns 011, 32ns 100, 101-111 reserved
// RL6 - unit pointer bit 8 selects shown unit
// RL7 - third sample has own register set
// RL8 - read-only, writes ignored, reserved zero
module etsss_top #(
  parameter ADDR_W = `ETSSS_ADDR_W
) (
  // clock and reset
  input wire ref_clk_i,
  input wire sys_rst_i,
  // register port
  input wire [ADDR_W-1:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [31:0] reg_rdata_o,
  // capture port
  input wire cap_valid_i,
  input wire cap_unit_i,
  input wire cap_third_i,
  input wire cap_rising_i,
  input wire [29:0] cap_nanos_i,
  input wire [31:0] cap_secs_i,
  input wire [2:0] cap_slot_i,
  // current unit pointer
  output reg unit_ptr_o
);

  localparam UNIT_CNT = 2;

  // capture phase encoding
  wire [2:0] cap_code;
  wire cap_bad;

  etsss_phase_enc u_enc (
    .slot_i(cap_slot_i),
    .code_o(cap_code),
    .bad_o(cap_bad)
  );

  // load strobes per unit and sample
  reg load_u0_s2;
  reg load_u0_s3;
  reg load_u1_s2;
  reg load_u1_s3;

  always @* begin
    load_u0_s2 = 1'b0;
    load_u0_s3 = 1'b0;
    load_u1_s2 = 1'b0;
    load_u1_s3 = 1'b0;
    if (cap_valid_i) begin
      case ({cap_unit_i, cap_third_i})
        2'b00: begin
          load_u0_s2 = 1'b1;
        end
        2'b01: begin
          load_u0_s3 = 1'b1; // [RL7]
        end
        2'b10: begin
          load_u1_s2 = 1'b1;
        end
        2'b11: begin
          load_u1_s3 = 1'b1; // [RL7]
        end
        default: begin
          load_u0_s2 = 1'b0;
        end
      endcase
    end
  end

  // stored words
  wire [31:0] u0_s2_nanos;
  wire [31:0] u0_s2_secs;
  wire [31:0] u0_s2_phase;
  wire [31:0] u0_s3_nanos;
  wire [31:0] u0_s3_secs;
  wire [31:0] u0_s3_phase;
  wire [31:0] u1_s2_nanos;
  wire [31:0] u1_s2_secs;
  wire [31:0] u1_s2_phase;
  wire [31:0] u1_s3_nanos;
  wire [31:0] u1_s3_secs;
  wire [31:0] u1_s3_phase;

  etsss_sample_slot u_u0_s2 (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .load_i(load_u0_s2),
    .rising_i(cap_rising_i),
    .nanos_i(cap_nanos_i),
    .secs_i(cap_secs_i),
    .phase_i(cap_code),
    .nanos_word_o(u0_s2_nanos),
    .secs_word_o(u0_s2_secs),
    .phase_word_o(u0_s2_phase)
  );

  etsss_sample_slot u_u0_s3 (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .load_i(load_u0_s3),
    .rising_i(cap_rising_i),
    .nanos_i(cap_nanos_i),
    .secs_i(cap_secs_i),
    .phase_i(cap_code),
    .nanos_word_o(u0_s3_nanos),
    .secs_word_o(u0_s3_secs),
    .phase_word_o(u0_s3_phase)
  );

  etsss_sample_slot u_u1_s2 (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .load_i(load_u1_s2),
    .rising_i(cap_rising_i),
    .nanos_i(cap_nanos_i),
    .secs_i(cap_secs_i),
    .phase_i(cap_code),
    .nanos_word_o(u1_s2_nanos),
    .secs_word_o(u1_s2_secs),
    .phase_word_o(u1_s2_phase)
  );

  etsss_sample_slot u_u1_s3 (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .load_i(load_u1_s3),
    .rising_i(cap_rising_i),
    .nanos_i(cap_nanos_i),
    .secs_i(cap_secs_i),
    .phase_i(cap_code),
    .nanos_word_o(u1_s3_nanos),
    .secs_word_o(u1_s3_secs),
    .phase_word_o(u1_s3_phase)
  );

  // unit pointer register
  reg ptr_reg;
  reg ptr_next;
  reg wr_index;
  reg wr_status;

  // write decode, sample registers have none
  always @* begin
    wr_index = 1'b0;
    wr_status = 1'b0;
    if (reg_wr_i) begin
      case (reg_addr_i)
        `ETSSS_OFS_UNIT_INDEX: begin
          wr_index = 1'b1;
        end
        `ETSSS_OFS_STATUS: begin
          wr_status = 1'b1;
        end
        default: begin
          wr_index = 1'b0;
        end
      endcase
    end
  end

  always @* begin
    ptr_next = ptr_reg;
    if (wr_index) begin
      ptr_next = reg_wdata_i[`ETSSS_PTR_BIT];
    end
  end

  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ptr_reg <= `ETSSS_RST_PTR;
    end else begin
      ptr_reg <= ptr_next;
    end
  end

  // sticky capture status per unit, bad-slot bit global
  reg [UNIT_CNT-1:0] valid2_reg;
  reg [UNIT_CNT-1:0] valid3_reg;
  reg [UNIT_CNT-1:0] ovr2_reg;
  reg [UNIT_CNT-1:0] ovr3_reg;
  reg bad_reg;
  reg [UNIT_CNT-1:0] valid2_next;
  reg [UNIT_CNT-1:0] valid3_next;
  reg [UNIT_CNT-1:0] ovr2_next;
  reg [UNIT_CNT-1:0] ovr3_next;
  reg bad_next;
  reg [UNIT_CNT-1:0] sel_mask;
  wire [UNIT_CNT-1:0] set2;
  wire [UNIT_CNT-1:0] set3;

  always @* begin
    case (ptr_reg)
      1'b1: begin
        sel_mask = 2'b10;
      end
      default: begin
        sel_mask = 2'b01;
      end
    endcase
  end
  assign set2 = {load_u1_s2, load_u0_s2};
  assign set3 = {load_u1_s3, load_u0_s3};

  always @* begin
    valid2_next = valid2_reg;
    valid3_next = valid3_reg;
    ovr2_next = ovr2_reg;
    ovr3_next = ovr3_reg;
    bad_next = bad_reg;
    // write one to clear, selected unit only, bad-slot bit global
    if (wr_status) begin
      if (reg_wdata_i[`ETSSS_ST_VALID2_BIT]) begin
        valid2_next = valid2_next & ~sel_mask;
      end
      if (reg_wdata_i[`ETSSS_ST_VALID3_BIT]) begin
        valid3_next = valid3_next & ~sel_mask;
      end
      if (reg_wdata_i[`ETSSS_ST_OVR2_BIT]) begin
        ovr2_next = ovr2_next & ~sel_mask;
      end
      if (reg_wdata_i[`ETSSS_ST_OVR3_BIT]) begin
        ovr3_next = ovr3_next & ~sel_mask;
      end
      if (reg_wdata_i[`ETSSS_ST_BADSLOT_BIT]) begin
        bad_next = 1'b0;
      end
    end
    // new capture wins over a clear
    ovr2_next = ovr2_next | (set2 & valid2_reg);
    ovr3_next = ovr3_next | (set3 & valid3_reg);
    valid2_next = valid2_next | set2;
    valid3_next = valid3_next | set3;
    if (cap_valid_i & cap_bad) begin
      bad_next = 1'b1;
    end
  end

  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      valid2_reg <= 2'h0;
      valid3_reg <= 2'h0;
      ovr2_reg <= 2'h0;
      ovr3_reg <= 2'h0;
      bad_reg <= 1'b0;
    end else begin
      valid2_reg <= valid2_next;
      valid3_reg <= valid3_next;
      ovr2_reg <= ovr2_next;
      ovr3_reg <= ovr3_next;
      bad_reg <= bad_next;
    end
  end

  // words of the unit the pointer selects
  reg [31:0] sel_s2_nanos;
  reg [31:0] sel_s2_secs;
  reg [31:0] sel_s2_phase;
  reg [31:0] sel_s3_nanos;
  reg [31:0] sel_s3_secs;
  reg [31:0] sel_s3_phase;
  reg [31:0] status_word;

  always @* begin
    case (ptr_reg)
      1'b1: begin
        sel_s2_nanos = u1_s2_nanos; // [RL6]
        sel_s2_secs = u1_s2_secs; // [RL6]
        sel_s2_phase = u1_s2_phase;
        sel_s3_nanos = u1_s3_nanos; // [RL6]
        sel_s3_secs = u1_s3_secs; // [RL6]
        sel_s3_phase = u1_s3_phase;
      end
      default: begin
        sel_s2_nanos = u0_s2_nanos; // [RL6]
        sel_s2_secs = u0_s2_secs; // [RL6]
        sel_s2_phase = u0_s2_phase;
        sel_s3_nanos = u0_s3_nanos; // [RL6]
        sel_s3_secs = u0_s3_secs; // [RL6]
        sel_s3_phase = u0_s3_phase;
      end
    endcase
  end

  // bad-slot bit global, rest per selected unit
  always @* begin
    status_word = `ETSSS_RST_WORD;
    status_word[`ETSSS_ST_VALID2_BIT] = valid2_reg[ptr_reg];
    status_word[`ETSSS_ST_VALID3_BIT] = valid3_reg[ptr_reg];
    status_word[`ETSSS_ST_OVR2_BIT] = ovr2_reg[ptr_reg];
    status_word[`ETSSS_ST_OVR3_BIT] = ovr3_reg[ptr_reg];
    status_word[`ETSSS_ST_BADSLOT_BIT] = bad_reg;
  end

  // read mux, registered one cycle later
  reg [31:0] rdata_next;

  always @* begin
    rdata_next = `ETSSS_RST_WORD;
    if (reg_rd_i) begin
      case (reg_addr_i)
        `ETSSS_OFS_S2_NANOS: begin
          rdata_next = sel_s2_nanos; // [RL1] [RL2]
        end
        `ETSSS_OFS_S2_SECS: begin
          rdata_next = sel_s2_secs; // [RL3]
        end
        `ETSSS_OFS_S2_PHASE: begin
          rdata_next = sel_s2_phase; // [RL4] [RL5]
        end
        `ETSSS_OFS_S3_NANOS: begin
          rdata_next = sel_s3_nanos; // [RL7]
        end
        `ETSSS_OFS_S3_SECS: begin
          rdata_next = sel_s3_secs; // [RL7]
        end
        `ETSSS_OFS_S3_PHASE: begin
          rdata_next = sel_s3_phase; // [RL7]
        end
        `ETSSS_OFS_UNIT_INDEX: begin
          rdata_next = 32'h0000_0000;
          rdata_next[`ETSSS_PTR_BIT] = ptr_reg;
        end
        `ETSSS_OFS_STATUS: begin
          rdata_next = status_word;
        end
        default: begin
          // unmapped reads return zero
          rdata_next = `ETSSS_RST_WORD;
        end
      endcase
    end
  end

  // sample registers have no write decode
  always @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= `ETSSS_RST_WORD;
      unit_ptr_o <= `ETSSS_RST_PTR;
    end else begin
      reg_rdata_o <= rdata_next; // [RL8]
      unit_ptr_o <= ptr_next;
    end
  end

endmodule

// ===== tb/etsss_props.sv
`timescale 1ns/1ps
module etsss_props #(
  parameter ADDR_W = 16
) (
  // clock
  input wire ref_clk_i,
  input wire sys_rst_i,
  // regs
  input wire [ADDR_W-1:0] reg_addr_i,
  input wire [31:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  input wire [31:0] reg_rdata_o,
  // capture
  input wire cap_valid_i,
  input wire cap_unit_i,
  input wire cap_third_i,
  input wire cap_rising_i,
  input wire [29:0] cap_nanos_i,
  input wire [31:0] cap_secs_i,
  input wire [2:0] cap_slot_i,
  input wire unit_ptr_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  wire ptr_wr = reg_wr_i && reg_addr_i == 16'h0500;
  wire cap_ok = cap_valid_i && !reg_wr_i && cap_unit_i == unit_ptr_o;
  wire ns_rd = reg_rd_i && (reg_addr_i == 16'h0560 || reg_addr_i == 16'h056c);
  wire ph_rd = reg_rd_i && (reg_addr_i == 16'h0568 || reg_addr_i == 16'h0574);
  property p_idle; !reg_rd_i |=> reg_rdata_o == 32'h0; endproperty
  property p_ptr; ptr_wr |=> unit_ptr_o == $past(reg_wdata_i[8]); endproperty
  property p_hold; !ptr_wr |=> $stable(unit_ptr_o); endproperty
  property p_ns31; ns_rd |=> !reg_rdata_o[31]; endproperty
  property p_phrsv; ph_rd |=> reg_rdata_o[31:3] == 29'h0; endproperty
  property p_phcode; ph_rd |=> reg_rdata_o[2:0] <= 3'h4; endproperty
  property p_unmap; reg_rd_i && reg_addr_i == 16'h0562 |=> reg_rdata_o == 32'h0; endproperty
  property p_cap2;
    cap_ok && !cap_third_i ##1 reg_rd_i && !cap_valid_i && reg_addr_i == 16'h0560
    |=> reg_rdata_o == {1'b0, $past(cap_rising_i, 2), $past(cap_nanos_i, 2)};
  endproperty
  property p_cap3;
    cap_ok && cap_third_i ##1 reg_rd_i && !cap_valid_i && reg_addr_i == 16'h0570
    |=> reg_rdata_o == $past(cap_secs_i, 2);
  endproperty
  a_idle: assert property (p_idle) else $error("idle data");
  a_ptr: assert property (p_ptr) else $error("pointer");
  a_hold: assert property (p_hold) else $error("pointer moved");
  a_ns31: assert property (p_ns31) else $error("bit 31 set");
  a_phrsv: assert property (p_phrsv) else $error("phase upper bits");
  a_phcode: assert property (p_phcode) else $error("phase code");
  a_unmap: assert property (p_unmap) else $error("unmapped data");
  a_cap2: assert property (p_cap2) else $error("second nanos");
  a_cap3: assert property (p_cap3) else $error("third secs");
  c_ptr: cover property (ptr_wr ##1 reg_rd_i);
  c_bad: cover property (cap_valid_i && cap_slot_i > 3'h4);
  c_wro: cover property (reg_wr_i && reg_addr_i == 16'h0560);
endmodule
bind etsss_top etsss_props #(.ADDR_W(ADDR_W)) i_props (
  .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
  .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
  .reg_rdata_o(reg_rdata_o), .cap_valid_i(cap_valid_i), .cap_unit_i(cap_unit_i),
  .cap_third_i(cap_third_i), .cap_rising_i(cap_rising_i), .cap_nanos_i(cap_nanos_i),
  .cap_secs_i(cap_secs_i), .cap_slot_i(cap_slot_i), .unit_ptr_o(unit_ptr_o)
);

// ===== tb/etsss_cap_src.sv
`timescale 1ns/1ps
module etsss_cap_src (
  // clock
  input wire ref_clk_i,
  // capture
  output reg cap_valid_o = 1'b0,
  output reg cap_unit_o = 1'b0,
  output reg cap_third_o = 1'b0,
  output reg cap_rising_o = 1'b0,
  output reg [29:0] cap_nanos_o = 30'h0,
  output reg [31:0] cap_secs_o = 32'h0,
  output reg [2:0] cap_slot_o = 3'h0
);
  // one strobe, then edge, nanos and secs lines scrambled
  task automatic fire(input u, input t, input r, input [29:0] n, input [31:0] s,
                      input [2:0] sl);
    cap_valid_o <= 1'b1;
    cap_unit_o <= u;
    cap_third_o <= t;
    cap_rising_o <= r;
    cap_nanos_o <= n;
    cap_secs_o <= s;
    cap_slot_o <= sl;
    @(posedge ref_clk_i);
    cap_valid_o <= 1'b0;
    cap_rising_o <= ~r;
    cap_nanos_o <= ~n;
    cap_secs_o <= ~s;
    #1;
  endtask
endmodule

// ===== tb/event_timestamp_sample_store_tb_top.sv
`timescale 1ns/1ps
module event_timestamp_sample_store_tb_top;
  reg ref_clk_i = 1'b0;
  reg sys_rst_i = 1'b1;
  reg [15:0] reg_addr_i = 16'h0;
  reg [31:0] reg_wdata_i = 32'h0;
  reg reg_wr_i = 1'b0;
  reg reg_rd_i = 1'b0;
  wire [31:0] reg_rdata_o;
  wire cap_valid_i, cap_unit_i, cap_third_i, cap_rising_i, unit_ptr_o;
  wire [29:0] cap_nanos_i;
  wire [31:0] cap_secs_i;
  wire [2:0] cap_slot_i;
  int num_errors = 0;
  int comparisons = 0;
  int cycles = 0;
  int i;
  initial begin
    forever #5 ref_clk_i = ~ref_clk_i;
  end
  etsss_top i_dut (
    .ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .cap_valid_i(cap_valid_i), .cap_unit_i(cap_unit_i),
    .cap_third_i(cap_third_i), .cap_rising_i(cap_rising_i), .cap_nanos_i(cap_nanos_i),
    .cap_secs_i(cap_secs_i), .cap_slot_i(cap_slot_i), .unit_ptr_o(unit_ptr_o)
  );
  etsss_cap_src i_src (
    .ref_clk_i(ref_clk_i), .cap_valid_o(cap_valid_i), .cap_unit_o(cap_unit_i),
    .cap_third_o(cap_third_i), .cap_rising_o(cap_rising_i), .cap_nanos_o(cap_nanos_i),
    .cap_secs_o(cap_secs_i), .cap_slot_o(cap_slot_i)
  );
  task automatic wr(input [15:0] a, input [31:0] d);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
    #1;
  endtask
  task automatic rd(input [15:0] a, input [31:0] exp);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    comparisons++;
    if (reg_rdata_o !== exp) begin
      num_errors++;
      $display("BAD reg %h exp %h got %h", a, exp, reg_rdata_o);
    end
  endtask
  task automatic chk_ptr(input exp);
    comparisons++;
    if (unit_ptr_o !== exp) begin
      num_errors++;
      $display("BAD unit_ptr_o exp %b got %b", exp, unit_ptr_o);
    end
  endtask
  task finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge ref_clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      num_errors++;
      finish_test;
    end
  end
  initial begin
    repeat (6) @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    @(posedge ref_clk_i);
    for (i = 0; i < 6; i++) rd(16'h0560 + 16'(4 * i), 32'h0);
    rd(16'h0500, 32'h0);
    $display("test reset done");
    i_src.fire(1'b0, 1'b0, 1'b1, 30'h2bcd_1234, 32'h0001_0203, 3'h2);
    rd(16'h0560, 32'h6bcd_1234);
    rd(16'h0564, 32'h0001_0203);
    rd(16'h0568, 32'h2);
    wr(16'h0560, 32'hffff_ffff);
    rd(16'h0560, 32'h6bcd_1234);
    rd(16'h0562, 32'h0);
    $display("test second done");
    for (i = 0; i < 8; i++) begin
      i_src.fire(1'b0, 1'b1, 1'b0, {27'h7ff_ffff, i[2:0]}, {16'hf00d, 13'h0, i[2:0]}, i[2:0]);
      rd(16'h0570, {16'hf00d, 13'h0, i[2:0]});
      rd(16'h056c, {5'h07, 24'hff_ffff, i[2:0]});
      rd(16'h0574, i < 5 ? 32'(i) : 32'h0);
    end
    $display("test third done");
    i_src.fire(1'b1, 1'b0, 1'b0, 30'h0000_0055, 32'h0000_0aaa, 3'h4);
    rd(16'h0560, 32'h6bcd_1234);
    wr(16'h0500, 32'h0000_0100);
    rd(16'h0500, 32'h0000_0100);
    rd(16'h0560, 32'h0000_0055);
    rd(16'h0564, 32'h0000_0aaa);
    rd(16'h0568, 32'h4);
    rd(16'h056c, 32'h0);
    wr(16'h0500, 32'hffff_feff);
    rd(16'h0500, 32'h0);
    rd(16'h0564, 32'h0001_0203);
    $display("test unit done");
    rd(16'h05f0, 32'h0000_001b);
    wr(16'h05f0, 32'h0000_001f);
    rd(16'h05f0, 32'h0);
    rd(16'h056c, 32'h3fff_ffff);
    wr(16'h0500, 32'h0000_0100);
    chk_ptr(1'b1);
    rd(16'h05f0, 32'h1);
    i_src.fire(1'b1, 1'b0, 1'b1, 30'h0000_0077, 32'h0000_0bbb, 3'h1);
    rd(16'h05f0, 32'h5);
    rd(16'h0568, 32'h1);
    rd(16'h0560, 32'h4000_0077);
    $display("test status done");
    sys_rst_i <= 1'b1;
    @(posedge ref_clk_i);
    sys_rst_i <= 1'b0;
    chk_ptr(1'b0);
    rd(16'h0560, 32'h0);
    rd(16'h05f0, 32'h0);
    $display("test reset again done");
    finish_test;
  end
endmodule
